// ==== include/io_port_defines.vh ====
`ifndef IO_PORT_DEFINES_VH
`define IO_PORT_DEFINES_VH

// ==========================================
// Sizes
`define PORT_PINS        16
`define RP_PINS          8
`define REMAP_OUTS       8
`define REMAP_INS        8
`define SEL_W            4
`define ADDR_W           12
`define DATA_W           16

// ==========================================
// Register offsets, byte addresses; table pages as address bits 11:8
`define ADDR_SLEW_HIGH   12'h000
`define ADDR_SLEW_LOW    12'h010
`define ADDR_REMAP_LOCK  12'h020
`define ADDR_OUT_SEL_PG  4'h1
`define ADDR_IN_SEL_PG   4'h2

// ==========================================
// Alias operations, taken from address bits 3:2
`define OP_WRITE         2'h0
`define OP_CLEAR         2'h1
`define OP_SET           2'h2
`define OP_INVERT        2'h3

// ==========================================
// Fields and reset values
`define LOCK_BIT         0
`define SLEW_RESET       16'h0000
`define SEL_RESET        4'h0
`define LOCK_RESET       1'h0
`define SEL_NONE         4'h0

// ==========================================
// Slew codes, {high, low}
`define SLEW_SLOWEST     2'h3
`define SLEW_SLOW        2'h2
`define SLEW_MEDIUM      2'h1
`define SLEW_FASTEST     2'h0

`endif

// ==== rtl/alias_reg.v ====
`timescale 1ns/1ns
`include "io_port_defines.vh"

module alias_reg #(
  parameter W = 16
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         wr_en,
  input  wire [1:0]   op,
  input  wire [W-1:0] wdata,
  output reg  [W-1:0] q
);

  // ==========================================
  // Plain write, or atomic clear, set, invert
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= {W{1'b0}};
    end else if (wr_en) begin
      case (op)
        `OP_CLEAR:  q <= q & ~wdata;
        `OP_SET:    q <= q | wdata;
        `OP_INVERT: q <= q ^ wdata;
        default:    q <= wdata;
      endcase
    end
  end

endmodule // alias_reg

// ==== rtl/remap_table.v ====
`timescale 1ns/1ns
`include "io_port_defines.vh"

module remap_table (
  input  wire                        clk,
  input  wire                        rst_n,
  input  wire                        wr_en,
  input  wire [3:0]                  wr_index,
  input  wire [1:0]                  op,
  input  wire [`SEL_W-1:0]           wdata,
  output wire [16*`SEL_W-1:0]        sel_flat
);

  // ==========================================
  // Entries 0..7 output selects, 8..15 input selects
  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1) begin : g_entry
      alias_reg #(.W(`SEL_W)) u_entry (
        .clk   (clk),
        .rst_n (rst_n),
        .wr_en (wr_en && (wr_index == i)),
        .op    (op),
        .wdata (wdata),
        .q     (sel_flat[i*`SEL_W +: `SEL_W])
      );
    end
  endgenerate

endmodule // remap_table

// ==== rtl/io_port_slew_remap_atomic.v ====
// What this block does
// - Two-bit high/low code sets pin slew
// - Bit n of each slew register drives pin n
// - Slew registers reset cleared, fastest edges
// - Every register has clear, set, invert aliases
// - Aliases sit at base plus 4, 8, C
// - Alias writes touch only bits written one
// - Alias reads meaningless; base read shows result
// - Remap inputs and outputs independently onto pins
// - Remappable pins indexed by remap number
// - Established mappings protected from stray writes
// - Remappable set covers serial, timer, clock signals
// - I2C and analog modules stay on fixed pins
// - Remapped peripheral reaches no pin until assigned
// - Fixed peripheral on default pin unless claimed
// - Active remapped peripheral overrides GPIO and fixed peripherals
// - Analog function beats any remapped peripheral
`timescale 1ns/1ns
`include "io_port_defines.vh"

module io_port_slew_remap_atomic (
  input  wire                         sys_clk,
  input  wire                         nrst,
  input  wire                         reg_wr,
  input  wire                         reg_rd,
  input  wire [`ADDR_W-1:0]           reg_addr,
  input  wire [`DATA_W-1:0]           reg_wdata,
  output reg  [`DATA_W-1:0]           reg_rdata,
  output reg  [2*`PORT_PINS-1:0]      slew_code,
  input  wire [`PORT_PINS-1:0]        gpio_out,
  input  wire [`PORT_PINS-1:0]        gpio_drive,
  input  wire [`PORT_PINS-1:0]        fixed_en,
  input  wire [`PORT_PINS-1:0]        fixed_out,
  input  wire [`PORT_PINS-1:0]        fixed_drive,
  input  wire [`PORT_PINS-1:0]        analog_sel,
  input  wire [`REMAP_OUTS-1:0]       periph_en,
  input  wire [`REMAP_OUTS-1:0]       periph_out,
  input  wire [`REMAP_OUTS-1:0]       periph_drive,
  output reg  [`REMAP_INS-1:0]        periph_in,
  input  wire [`PORT_PINS-1:0]        pin_in,
  output reg  [`PORT_PINS-1:0]        pin_out,
  output reg  [`PORT_PINS-1:0]        pin_oe_n,
  output reg                          remap_locked
);

  // ==========================================
  // Reset release
  reg        rst_meta;
  reg        rst_n;

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ==========================================
  // Address decode
  wire [`ADDR_W-1:0] base_addr;
  wire [1:0]         op;
  wire [3:0]         page;
  reg                hit_high;
  reg                hit_low;
  reg                hit_lock;
  reg                hit_table;
  reg  [3:0]         table_index;

  assign base_addr = {reg_addr[`ADDR_W-1:4], 4'h0};
  assign op        = reg_addr[3:2];
  assign page      = reg_addr[11:8];

  always @* begin
    hit_high    = 1'b0;
    hit_low     = 1'b0;
    hit_lock    = 1'b0;
    hit_table   = 1'b0;
    table_index = 4'h0;
    if (base_addr == `ADDR_SLEW_HIGH) begin
      hit_high = 1'b1;
    end else if (base_addr == `ADDR_SLEW_LOW) begin
      hit_low = 1'b1;
    end else if (base_addr == `ADDR_REMAP_LOCK) begin
      hit_lock = 1'b1;
    end else if (page == `ADDR_OUT_SEL_PG && reg_addr[7] == 1'b0) begin
      hit_table   = 1'b1;
      table_index = {1'b0, reg_addr[6:4]};
    end else if (page == `ADDR_IN_SEL_PG && reg_addr[7] == 1'b0) begin
      hit_table   = 1'b1;
      table_index = {1'b1, reg_addr[6:4]};
    end
  end

  // ==========================================
  // Write enables, mapping writes dropped while locked
  wire [0:0]              lock_q;
  wire                    wr_high;
  wire                    wr_low;
  wire                    wr_lock;
  wire                    wr_table;

  assign wr_high  = reg_wr && hit_high;
  assign wr_low   = reg_wr && hit_low;
  assign wr_lock  = reg_wr && hit_lock;
  assign wr_table = reg_wr && hit_table && !lock_q[0];

  // ==========================================
  // Registers with clear, set, invert aliases
  wire [`DATA_W-1:0]      slew_high_sel;
  wire [`DATA_W-1:0]      slew_low_sel;
  wire [16*`SEL_W-1:0]    sel_flat;

  alias_reg #(.W(`DATA_W)) u_slew_high (
    .clk   (sys_clk),
    .rst_n (rst_n),
    .wr_en (wr_high),
    .op    (op),
    .wdata (reg_wdata),
    .q     (slew_high_sel)
  );

  alias_reg #(.W(`DATA_W)) u_slew_low (
    .clk   (sys_clk),
    .rst_n (rst_n),
    .wr_en (wr_low),
    .op    (op),
    .wdata (reg_wdata),
    .q     (slew_low_sel)
  );

  // Lock stays writable so software can always undo it
  alias_reg #(.W(1)) u_lock (
    .clk   (sys_clk),
    .rst_n (rst_n),
    .wr_en (wr_lock),
    .op    (op),
    .wdata (reg_wdata[`LOCK_BIT]),
    .q     (lock_q)
  );

  remap_table u_table (
    .clk      (sys_clk),
    .rst_n    (rst_n),
    .wr_en    (wr_table),
    .wr_index (table_index),
    .op       (op),
    .wdata    (reg_wdata[`SEL_W-1:0]),
    .sel_flat (sel_flat)
  );

  // ==========================================
  // Read path, aliases read as zero
  reg  [`DATA_W-1:0]      next_rdata;
  wire [`SEL_W-1:0]       table_word;

  assign table_word = sel_flat[table_index*`SEL_W +: `SEL_W];

  always @* begin
    next_rdata = {`DATA_W{1'b0}};
    if (op == `OP_WRITE) begin
      if (hit_high) begin
        next_rdata = slew_high_sel;
      end else if (hit_low) begin
        next_rdata = slew_low_sel;
      end else if (hit_lock) begin
        next_rdata = {{(`DATA_W-1){1'b0}}, lock_q};
      end else if (hit_table) begin
        next_rdata = {{(`DATA_W-`SEL_W){1'b0}}, table_word};
      end
    end
  end

  // ==========================================
  // Pin priority: analog, remapped, fixed, GPIO
  wire [`PORT_PINS-1:0]   next_pin_out;
  wire [`PORT_PINS-1:0]   next_pin_oe_n;
  wire [`REMAP_INS-1:0]   next_periph_in;

  // Select v in 1..limit names slot v-1, anything else nothing
  function sel_valid;
    input [`SEL_W-1:0] sel;
    input integer      limit;
    begin
      sel_valid = (sel != `SEL_NONE) && (sel <= limit);
    end
  endfunction

  // Slot of a select, meaningful only where sel_valid holds
  function [2:0] sel_slot;
    input [`SEL_W-1:0] sel;
    reg   [`SEL_W-1:0] idx;
    begin
      idx      = sel - 4'h1;
      sel_slot = idx[2:0];
    end
  endfunction

  genvar g;

  generate
    // Output side, one mux per port pin
    for (g = 0; g < `PORT_PINS; g = g + 1) begin : g_pin
      wire [`SEL_W-1:0] out_sel;
      wire [2:0]        slot;
      wire              remapped;
      reg               drv_val;
      reg               drv_oe_n;

      if (g < `RP_PINS) begin : g_rp
        assign out_sel = sel_flat[g*`SEL_W +: `SEL_W];
      end else begin : g_plain
        // Upper pins are never remappable
        assign out_sel = `SEL_NONE;
      end

      assign slot     = sel_slot(out_sel);
      assign remapped = sel_valid(out_sel, `REMAP_OUTS) && periph_en[slot];

      // Highest priority first
      always @* begin
        drv_val  = 1'b0;
        drv_oe_n = 1'b1;
        if (analog_sel[g]) begin
          drv_oe_n = 1'b1;
        end else if (remapped) begin
          drv_val  = periph_out[slot];
          drv_oe_n = ~periph_drive[slot];
        end else if (fixed_en[g]) begin
          drv_val  = fixed_out[g];
          drv_oe_n = ~fixed_drive[g];
        end else begin
          drv_val  = gpio_out[g];
          drv_oe_n = ~gpio_drive[g];
        end
      end

      assign next_pin_out[g]  = drv_val;
      assign next_pin_oe_n[g] = drv_oe_n;
    end

    // Input side, one selector per remappable peripheral input
    for (g = 0; g < `REMAP_INS; g = g + 1) begin : g_in
      wire [`SEL_W-1:0] in_sel;
      wire [2:0]        slot;
      wire              usable;

      assign in_sel = sel_flat[(g+`REMAP_OUTS)*`SEL_W +: `SEL_W];
      assign slot   = sel_slot(in_sel);
      // Analog pins read as 0 to remapped inputs
      assign usable = sel_valid(in_sel, `RP_PINS) && !analog_sel[slot];

      assign next_periph_in[g] = usable ? pin_in[slot] : 1'b0;
    end
  endgenerate

  // ==========================================
  // Slew code per pin, {high, low}
  wire [2*`PORT_PINS-1:0] next_slew;

  generate
    for (g = 0; g < `PORT_PINS; g = g + 1) begin : g_slew
      assign next_slew[2*g+1] = slew_high_sel[g];
      assign next_slew[2*g]   = slew_low_sel[g];
    end
  endgenerate

  // ==========================================
  // Register side output flops
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata    <= {`DATA_W{1'b0}};
      remap_locked <= `LOCK_RESET;
    end else begin
      // Read data holds until the next read strobe
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
      remap_locked <= lock_q[0];
    end
  end

  // ==========================================
  // Pin side output flops
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      slew_code    <= {2*`PORT_PINS{1'b0}};
      pin_out      <= {`PORT_PINS{1'b0}};
      pin_oe_n     <= {`PORT_PINS{1'b1}};
      periph_in    <= {`REMAP_INS{1'b0}};
    end else begin
      slew_code    <= next_slew;
      pin_out      <= next_pin_out;
      pin_oe_n     <= next_pin_oe_n;
      periph_in    <= next_periph_in;
    end
  end

endmodule // io_port_slew_remap_atomic

// ==== bench/io_port_slew_remap_atomic_assertions.sv ====
`timescale 1ns/1ns
`include "io_port_defines.vh"
module io_port_checker (
  input wire               sys_clk,
  input wire               nrst,
  input wire               reg_wr,
  input wire               reg_rd,
  input wire [`ADDR_W-1:0] reg_addr,
  input wire [`DATA_W-1:0] reg_wdata,
  input wire [`DATA_W-1:0] reg_rdata,
  input wire [31:0]        slew_code,
  input wire [15:0]        analog_sel,
  input wire [15:0]        pin_oe_n,
  input wire               remap_locked
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // ==========================================
  // Alias writes seen two edges later
  property p_wr(a, b, v);
    reg_wr && reg_addr == a && reg_wdata[b] ##1 !reg_wr |=> v;
  endproperty
  chk_reset_fast: assert property ($rose(nrst) |-> slew_code == 32'h0)
    else $error("slew code not cleared at reset");
  chk_set_high: assert property (p_wr(12'h008, 0, slew_code[1]))
    else $error("set alias missed");
  chk_clear_high: assert property (p_wr(12'h004, 0, !slew_code[1]))
    else $error("clear alias missed");
  chk_set_low: assert property (p_wr(12'h018, 0, slew_code[0]))
    else $error("low slew bit not in code");
  chk_lock_set: assert property (p_wr(12'h028, 0, remap_locked))
    else $error("lock not set");
  chk_lock_clear: assert property (p_wr(12'h024, 0, !remap_locked))
    else $error("lock not cleared");
  chk_invert_flip: assert property (!reg_wr ##1 (reg_wr && reg_addr == 12'h00C &&
    reg_wdata[3]) ##1 !reg_wr |=> slew_code[7] != $past(slew_code[7], 2))
    else $error("invert alias missed");
  chk_alias_read: assert property (reg_rd && reg_addr[3:2] != 2'h0 |=>
    reg_rdata == 16'h0000) else $error("alias read not zero");
  chk_analog_off: assert property (|analog_sel |=>
    (pin_oe_n & $past(analog_sel)) == $past(analog_sel)) else $error("analog pin driven");
  cover property (reg_wr && reg_addr == 12'h100);
  cover property (remap_locked && reg_wr);
  cover property (|analog_sel);
endmodule // io_port_checker
bind io_port_slew_remap_atomic io_port_checker u_chk (.sys_clk, .nrst, .reg_wr, .reg_rd,
  .reg_addr, .reg_wdata, .reg_rdata, .slew_code, .analog_sel, .pin_oe_n, .remap_locked);

// ==== bench/pin_partner.sv ====
`timescale 1ns/1ns
module pin_partner (
  input  wire        sys_clk,
  input  wire [15:0] pin_out,
  input  wire [15:0] pin_oe_n,
  output wire [15:0] pin_in
);
  reg [15:0] float_lvl = 16'h5A5A;
  // Released pins wander every cycle
  always @(posedge sys_clk) float_lvl <= ~float_lvl;
  assign pin_in = (pin_out & ~pin_oe_n) | (float_lvl & pin_oe_n);
endmodule // pin_partner

// ==== bench/tb_io_port_slew_remap_atomic.sv ====
`timescale 1ns/1ns
`include "io_port_defines.vh"
module tb_io_port_slew_remap_atomic;
  reg         sys_clk, nrst, reg_wr, reg_rd;
  reg  [11:0] reg_addr;
  reg  [15:0] reg_wdata, gpio_out, gpio_drive, fixed_en, fixed_out, fixed_drive, analog_sel;
  reg  [7:0]  periph_en, periph_out, periph_drive;
  wire [15:0] reg_rdata, pin_in, pin_out, pin_oe_n;
  wire [31:0] slew_code;
  wire [7:0]  periph_in;
  wire        remap_locked;
  integer     fails = 0;
  integer     check_count = 0;
  integer     k;
  reg  [31:0] rnd = 32'h0AA99F89;
  reg  [15:0] shadow [0:1];
  reg  [15:0] d;
  reg  [1:0]  op;
  reg         b;

  io_port_slew_remap_atomic dut (.sys_clk, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .slew_code, .gpio_out, .gpio_drive, .fixed_en, .fixed_out, .fixed_drive,
    .analog_sel, .periph_en, .periph_out, .periph_drive, .periph_in, .pin_in, .pin_out,
    .pin_oe_n, .remap_locked);
  pin_partner far_side (.sys_clk, .pin_out, .pin_oe_n, .pin_in);

  // ==========================================
  // Helpers
  function [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function [15:0] alias_op(input [1:0] o, input [15:0] q, input [15:0] v);
    case (o)
      `OP_WRITE: alias_op = v;
      `OP_CLEAR: alias_op = q & ~v;
      `OP_SET:   alias_op = q | v;
      default:   alias_op = q ^ v;
    endcase
  endfunction
  function [31:0] weave(input [15:0] hi, input [15:0] lo);
    integer n;
    for (n = 0; n < 16; n = n + 1)
      weave[2*n +: 2] = {hi[n], lo[n]};
  endfunction
  task chk(input [255:0] what, input [31:0] exp, input [31:0] seen);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("CHECK FAILED %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(negedge sys_clk);
  endtask
  task wr(input [11:0] a, input [15:0] v);
    begin
      @(negedge sys_clk);
      {reg_wr, reg_addr, reg_wdata} = {1'b1, a, v};
      @(negedge sys_clk);
      reg_wr = 1'b0;
    end
  endtask
  task rd(input [11:0] a);
    begin
      @(negedge sys_clk);
      {reg_rd, reg_addr} = {1'b1, a};
      @(negedge sys_clk);
      reg_rd = 1'b0;
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    #2000000;
    fails = fails + 1;
    wrap_up;
  end

  // ==========================================
  // Main sequence
  initial begin
    {nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = 31'h0;
    {gpio_out, fixed_en, fixed_out, analog_sel} = 64'h0;
    {gpio_drive, fixed_drive} = 32'hFFFFFFFF;
    {periph_en, periph_out, periph_drive} = 24'h0;
    shadow[0] = 16'h0000;
    shadow[1] = 16'h0000;
    tick(3);
    nrst = 1'b1;
    tick(3);
    chk("reset slew", 32'h0, slew_code);
    for (k = 0; k < 24; k = k + 1) begin
      rnd = lfsr(rnd);
      b = k[0];
      op = k[2:1];
      d = rnd[15:0] | 16'h0009;
      wr({7'h0, b, op, 2'h0}, d);
      shadow[b] = alias_op(op, shadow[b], d);
      rd({7'h0, b, 4'h0});
      chk("base read", shadow[b], reg_rdata);
      rd({7'h0, b, op | 2'h1, 2'h0});
      chk("alias read", 16'h0000, reg_rdata);
      chk("slew code", weave(shadow[0], shadow[1]), slew_code);
    end
    wr(12'h000, 16'h0001);
    wr(12'h010, 16'h0000);
    tick(1);
    chk("pin0 slow", 32'h2, slew_code);
    rnd = lfsr(rnd);
    gpio_out = rnd[15:0];
    {periph_en, periph_out} = {8'h01, ~rnd[7:0]};
    {fixed_en, fixed_out} = {16'h0002, ~rnd[15:0]};
    periph_drive = 8'hFF;
    tick(2);
    chk("pin0 unassigned", gpio_out[0], pin_out[0]);
    chk("pin1 fixed", fixed_out[1], pin_out[1]);
    wr(12'h100, 16'h0001);
    wr(12'h200, 16'h0002);
    tick(3);
    chk("pin0 remapped", {periph_out[0], 1'b0}, {pin_out[0], pin_oe_n[0]});
    chk("input remap", {1'b0, fixed_out[1]}, periph_in[1:0]);
    wr(12'h028, 16'h0001);
    wr(12'h100, 16'h0000);
    rd(12'h020);
    chk("lock read", 16'h0001, reg_rdata);
    chk("locked map", periph_out[0], pin_out[0]);
    analog_sel = 16'h0001;
    tick(2);
    chk("analog wins", 1'b1, pin_oe_n[0]);
    analog_sel = 16'h0000;
    wr(12'h024, 16'h0001);
    wr(12'h100, 16'h0000);
    tick(2);
    chk("unlocked map", gpio_out[0], pin_out[0]);
    wrap_up;
  end
endmodule // tb_io_port_slew_remap_atomic
